// ===== bench/frame_store_model.sv
// Purpose: Frame store and sensor stand-in
// Assumes: 12x6 frame, two idle pixels per line
// Notes: Store time alternates short and long
`timescale 1ns/1ns
module frame_store_model (
  // Inputs
  input wire logic i_clk,
  input wire logic i_cap_start,
  input wire logic i_frame_req,
  input wire logic i_play,
  input wire logic i_snap,
  // Outputs
  output logic o_stored,
  output roi_seq_pkg::video_t o_video
);
  logic slow = 1'b0;
  initial begin
    o_stored = 1'b0;
    o_video = '0;
    forever begin
      @(posedge i_clk);
      if (i_cap_start === 1'b1 || i_snap === 1'b1) begin
        slow = ~slow;
        repeat (slow ? 20 : 1) @(posedge i_clk);
        o_stored <= 1'b1;
        @(posedge i_clk);
        o_stored <= 1'b0;
      end else if (i_frame_req === 1'b1 || i_play === 1'b1) begin
        for (int y = 0; y < 6; y++) begin
          for (int x = 0; x < 14; x++) begin
            // Gap pixels are junk, never the last value
            o_video <= '{1'b1, x < 12, x < 12 ? 8'(y * 12 + x) : ~o_video.pix};
            @(posedge i_clk);
          end
        end
        o_video <= '{1'b0, 1'b0, ~o_video.pix};
      end
    end
  end
endmodule

// ===== bench/roi_seq_chk.sv
// Purpose: Port checks for the readout controller
// Assumes: One clock, synchronous reset
// Notes: Bound to the top module
`timescale 1ns/1ns
module roi_seq_chk (
  // Bus side
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Engine side
  input wire logic i_trigger,
  input wire roi_seq_pkg::video_t i_video,
  input wire logic o_cap_start,
  input wire logic [23:0] o_exposure,
  input wire logic [7:0] o_gain,
  input wire roi_seq_pkg::video_t o_video
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_one_wait;
    !o_pready ##1 o_pready;
  endsequence
  a_one_wait: assert property (i_psel && i_penable && !$past(i_penable) |-> s_one_wait)
    else $error("pready not after one wait");
  a_ready_cause: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  a_err_zero: assert property (o_pslverr && !i_pwrite |-> o_pready && o_prdata == 32'h0)
    else $error("refused read not zero");
  a_cap_cause: assert property (o_cap_start |-> $past(i_trigger, 3))
    else $error("capture without trigger");
  a_cap_once: assert property (o_cap_start |=> !o_cap_start [*3])
    else $error("capture repeated");
  a_exp_hold: assert property ($changed({o_gain, o_exposure}) |-> o_cap_start)
    else $error("exposure moved off capture");
  a_line_follow: assert property (o_video.line_valid |-> $past(i_video.line_valid)
    && o_video.pix == $past(i_video.pix))
    else $error("line data not from input");
  a_frame_follow: assert property (o_video.frame_valid |-> $past(i_video.frame_valid))
    else $error("frame flag not from input");
endmodule
bind roi_sequence_readout_control roi_seq_chk u_chk (.*);

// ===== bench/tb.sv
// Purpose: Self-checking bench for the readout controller
// Assumes: Frame store model on the far side
// Notes: Settle time after sequence reset is scaled down
`timescale 1ns/1ns
module tb;
  logic i_clk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_trigger = 1'b0, i_xfer_trigger = 1'b0, play = 1'b0, snap = 1'b0, serr;
  logic [3:0] i_pstrb = 4'hf;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, q, capv;
  logic i_frame_stored, o_pready, o_pslverr, o_cap_start, o_frame_req;
  logic [31:0] o_prdata;
  logic [23:0] o_exposure;
  logic [7:0] o_gain;
  logic [3:0] o_active_index;
  roi_seq_pkg::video_t i_video, o_video;
  int mismatches = 0, samples_checked = 0, seed = 32, cap_cnt = 0, pix_cnt = 0, req_cnt = 0;
  int tbl[10][8], cur, rep, used, c0, p0, r0;
  int fw[8] = '{12, 12, 12, 12, 24, 8, 8, 4};
  int dv[8] = '{1600, 1200, 16, 4, 24501, 1, 1, 0};
  int geo[12][3] = '{'{0, 0, 4}, '{0, 1, 3}, '{0, 2, 2}, '{0, 3, 1}, '{0, 6, 2}, '{0, 7, 3},
    '{3, 0, 5}, '{3, 1, 2}, '{3, 2, 0}, '{3, 3, 4}, '{3, 6, 1}, '{3, 7, 0}};
  int mg[9][3] = '{'{0, 0, 3}, '{0, 1, 2}, '{0, 2, 1}, '{0, 3, 0}, '{0, 7, 1},
    '{1, 0, 4}, '{1, 1, 3}, '{1, 2, 2}, '{1, 3, 1}};
  always #25 i_clk = ~i_clk;
  roi_sequence_readout_control dut (.*);
  frame_store_model fsm (.i_clk(i_clk), .i_cap_start(o_cap_start), .i_frame_req(o_frame_req),
    .i_play(play), .i_snap(snap), .o_stored(i_frame_stored), .o_video(i_video));
  always @(posedge i_clk) begin
    if (o_video.line_valid === 1'b1) pix_cnt++;
    if (o_frame_req === 1'b1) req_cnt++;
    if (o_cap_start === 1'b1) begin
      cap_cnt++;
      capv = {o_gain, o_exposure};
    end
  end
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(ref int c, input int v);
    int n;
    n = 0;
    while (c < v) begin
      @(posedge i_clk);
      if (++n > 3000) begin
        mismatches++;
        print_verdict();
      end
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      if (++n > 50) begin
        mismatches++;
        print_verdict();
      end
    end while (o_pready !== 1'b1);
    q = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic set(input int i, input int f, input int v);
    apb(1'b1, 12'h008, 32'(i));
    apb(1'b1, 12'(16 + 4 * f), 32'(v));
    tbl[i][f] = v;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      for (int f = 0; f < 8; f++) begin
        apb(1'b1, 12'h008, 32'(i));
        apb(1'b0, 12'(16 + 4 * f), 32'h0);
        chk(q, 32'(dv[f]));
        set(i, f, $random(seed) & ((1 << fw[f]) - 1));
        apb(1'b0, 12'(16 + 4 * f), 32'h0);
        chk(q, 32'(tbl[i][f]));
      end
    end
    apb(1'b0, 12'h0fc, 32'h0);
    chk({q[30:0], serr}, 32'h1);
    for (int k = 0; k < 12; k++) set(geo[k][0], geo[k][1], geo[k][2]);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h000, 32'h19);
    repeat (200) @(posedge i_clk);
    cur = 0;
    rep = 0;
    used = 0;
    for (int t = 0; t < 7; t++) begin
      c0 = cap_cnt;
      p0 = pix_cnt;
      r0 = req_cnt;
      i_trigger <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_trigger <= 1'b0;
      if (rep == 2) begin
        repeat (40) @(posedge i_clk);
        chk(32'(cap_cnt - c0), 32'h0);
      end else begin
        wt(cap_cnt, c0 + 1);
        chk(capv, 32'({tbl[cur][5][7:0], tbl[cur][4][23:0]}));
        chk(32'(o_active_index), 32'(cur));
        repeat (30) @(posedge i_clk);
        chk(32'(req_cnt - r0), 32'h0);
        i_xfer_trigger <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_xfer_trigger <= 1'b0;
        wt(pix_cnt, p0 + tbl[cur][0] * tbl[cur][1]);
        repeat (100) @(posedge i_clk);
        chk(32'(pix_cnt - p0), 32'(tbl[cur][0] * tbl[cur][1]));
        if (++used >= tbl[cur][6]) begin
          used = 0;
          cur = tbl[cur][7];
          if (cur == 0) rep++;
        end
      end
    end
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(q, 32'(tbl[0][0] / 2));
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(q, 32'(tbl[0][0] / 2));
    p0 = pix_cnt;
    play <= 1'b1;
    @(posedge i_clk);
    play <= 1'b0;
    wt(pix_cnt, p0 + 72);
    repeat (20) @(posedge i_clk);
    chk(32'(pix_cnt - p0), 32'h48);
    // Two overlapping regions chained 0 then 1, delay off
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, 12'h00c, 32'(mg[k][0]));
      apb(1'b1, 12'(48 + 4 * mg[k][1]), 32'(mg[k][2]));
    end
    apb(1'b1, 12'h000, 32'h2);
    p0 = pix_cnt;
    r0 = req_cnt;
    snap <= 1'b1;
    @(posedge i_clk);
    snap <= 1'b0;
    wt(pix_cnt, p0 + mg[0][2] * mg[1][2] + mg[5][2] * mg[6][2]);
    repeat (100) @(posedge i_clk);
    chk(32'(pix_cnt - p0), 32'(mg[0][2] * mg[1][2] + mg[5][2] * mg[6][2]));
    chk(32'(req_cnt - r0), 32'h2);
    chk(32'(o_active_index), 32'h0);
    print_verdict();
  end
endmodule

// ===== src/roi_seq_pkg.sv
// Purpose: Shared constants, layouts and helpers for the readout sequencer
// Assumes: 8-bit pixel stream, APB register access with 32-bit data
// Notes: Table entries are packed structs shared by engine and table memory
package roi_seq_pkg;

  // Table geometry
  localparam int SEQ_ENTRIES = 10;
  localparam int MULTI_ENTRIES = 5;
  localparam int GEO_W = 12;
  localparam int EXP_W = 24;
  localparam int GAIN_W = 8;
  localparam int CNT_W = 8;
  localparam int IDX_W = 4;
  localparam int POS_W = 13;
  localparam int PIX_W = 8;

  // Readout mode selector codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SEQ = 2'h1;
  localparam logic [1:0] MODE_MULTI = 2'h2;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_REPEAT = 12'h004;
  localparam logic [11:0] OFS_SEQ_SEL = 12'h008;
  localparam logic [11:0] OFS_MULTI_SEL = 12'h00c;
  localparam logic [11:0] OFS_SEQ_FLD = 12'h010;
  localparam logic [11:0] OFS_MULTI_FLD = 12'h030;
  localparam logic [11:0] OFS_STATUS = 12'h050;

  // Control register bit positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BIN = 2;
  localparam int CTRL_DELAY = 3;
  localparam int CTRL_SEQ_RST = 4;

  // Entry field indexes, one word each inside a field block
  localparam logic [2:0] FLD_WIDTH = 3'h0;
  localparam logic [2:0] FLD_HEIGHT = 3'h1;
  localparam logic [2:0] FLD_OFFX = 3'h2;
  localparam logic [2:0] FLD_OFFY = 3'h3;
  localparam logic [2:0] FLD_EXPOSURE = 3'h4;
  localparam logic [2:0] FLD_GAIN = 3'h5;
  localparam logic [2:0] FLD_FCOUNT = 3'h6;
  localparam logic [2:0] FLD_NEXT = 3'h7;

  // Values after reset
  localparam logic [GEO_W-1:0] RST_WIDTH = 12'h640;
  localparam logic [GEO_W-1:0] RST_HEIGHT = 12'h4b0;
  localparam logic [GEO_W-1:0] RST_OFFX = 12'h010;
  localparam logic [GEO_W-1:0] RST_OFFY = 12'h004;
  localparam logic [EXP_W-1:0] RST_EXPOSURE = 24'h005fb5;
  localparam logic [GAIN_W-1:0] RST_GAIN = 8'h01;
  localparam logic [CNT_W-1:0] RST_FCOUNT = 8'h01;
  localparam logic [IDX_W-1:0] RST_NEXT = 4'h0;
  localparam logic [CNT_W-1:0] RST_REPEAT = 8'h01;

  typedef struct packed {
    logic [IDX_W-1:0] next;
    logic [CNT_W-1:0] fcount;
    logic [GAIN_W-1:0] gain;
    logic [EXP_W-1:0] exposure;
    logic [GEO_W-1:0] offy;
    logic [GEO_W-1:0] offx;
    logic [GEO_W-1:0] height;
    logic [GEO_W-1:0] width;
  } entry_t;

  localparam entry_t ENTRY_DEFAULT = '{next: RST_NEXT, fcount: RST_FCOUNT, gain: RST_GAIN,
    exposure: RST_EXPOSURE, offy: RST_OFFY, offx: RST_OFFX, height: RST_HEIGHT,
    width: RST_WIDTH};

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    logic [2:0] field;
    logic [31:0] data;
  } tbl_wr_t;

  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic [PIX_W-1:0] pix;
  } video_t;

  function automatic entry_t set_field(entry_t e, logic [2:0] f, logic [31:0] d);
    entry_t r;
    r = e;
    unique case (f)
      FLD_WIDTH: r.width = d[GEO_W-1:0];
      FLD_HEIGHT: r.height = d[GEO_W-1:0];
      FLD_OFFX: r.offx = d[GEO_W-1:0];
      FLD_OFFY: r.offy = d[GEO_W-1:0];
      FLD_EXPOSURE: r.exposure = d[EXP_W-1:0];
      FLD_GAIN: r.gain = d[GAIN_W-1:0];
      FLD_FCOUNT: r.fcount = d[CNT_W-1:0];
      FLD_NEXT: r.next = d[IDX_W-1:0];
    endcase
    return r;
  endfunction

  function automatic logic [31:0] get_field(entry_t e, logic [2:0] f);
    logic [31:0] r;
    r = 32'h0;
    unique case (f)
      FLD_WIDTH: r[GEO_W-1:0] = e.width;
      FLD_HEIGHT: r[GEO_W-1:0] = e.height;
      FLD_OFFX: r[GEO_W-1:0] = e.offx;
      FLD_OFFY: r[GEO_W-1:0] = e.offy;
      FLD_EXPOSURE: r[EXP_W-1:0] = e.exposure;
      FLD_GAIN: r[GAIN_W-1:0] = e.gain;
      FLD_FCOUNT: r[CNT_W-1:0] = e.fcount;
      FLD_NEXT: r[IDX_W-1:0] = e.next;
    endcase
    return r;
  endfunction

endpackage

// ===== src/roi_sequence_readout_control.sv
// Purpose: Readout control for normal, sequence trigger and multi-region modes
// Assumes: Captured frames sit in an upstream frame store replayed on request
// Notes: Pixel stream is on i_clk; trigger pins are synchronised here
// Contract
// - A mode selector picks normal, sequence or multi-region readout.
// - Normal mode streams the image continuously without region or exposure control.
// - Sequence mode holds ten entries with region, exposure and gain each.
// - Each trigger in sequence mode captures one image with the current entry.
// - An entry is used for its frame count of frames before moving on.
// - After an entry finishes, the entry named by its next index follows.
// - Sequence table acts only while sequence mode is selected.
// - Entries reset to 1600x1200, offset 16/4, exposure 24501, gain 1, count 1.
// - Repetition 1 to 255 repeats the sequence; 0 repeats forever.
// - Turning binning on halves stored region values; turning it off keeps them.
// - Sequence mode uses asynchronous accumulation; triggers must avoid synchronous timing.
// - Multi-region mode cuts up to five regions from one captured image.
// - Multi-region settings act only while multi-region mode is selected.
// - Each region holds width, height, offsets and a next index.
// - Overlapping regions are accepted and each is read out in full.
// - Delayed readout lets cameras on a shared trigger stagger transfers.
`timescale 1ns/1ns
module roi_sequence_readout_control (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Trigger pins, asynchronous
  input wire logic i_trigger,
  input wire logic i_xfer_trigger,
  // Sensor and frame store side
  input wire roi_seq_pkg::video_t i_video,
  input wire logic i_frame_stored,
  output logic o_cap_start,
  output logic [roi_seq_pkg::EXP_W-1:0] o_exposure,
  output logic [roi_seq_pkg::GAIN_W-1:0] o_gain,
  output logic o_frame_req,
  // Image stream out
  output roi_seq_pkg::video_t o_video,
  output logic [roi_seq_pkg::IDX_W-1:0] o_active_index
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_LATCH,
    ST_ARM,
    ST_CAPTURE,
    ST_XFER_WAIT,
    ST_STREAM,
    ST_DONE
  } eng_state_t;

  typedef struct packed {
    // Registers
    logic [1:0] mode;
    logic binning;
    logic delay_en;
    logic [roi_seq_pkg::CNT_W-1:0] repeat_cnt;
    logic [roi_seq_pkg::IDX_W-1:0] seq_sel;
    logic [roi_seq_pkg::IDX_W-1:0] multi_sel;
    logic apb_wait;
    logic [31:0] prdata;
    logic slverr;
    // Synchronisers and edge history
    logic [1:0] trg_s;
    logic trg_d;
    logic [1:0] xfr_s;
    logic xfr_d;
    logic fv_d;
    logic lv_d;
    // Engine
    eng_state_t st;
    logic [roi_seq_pkg::IDX_W-1:0] cur;
    roi_seq_pkg::entry_t ent;
    logic [roi_seq_pkg::CNT_W-1:0] fcnt;
    logic [roi_seq_pkg::CNT_W-1:0] rep;
    logic [2:0] rcnt;
    logic [roi_seq_pkg::POS_W-1:0] x;
    logic [roi_seq_pkg::POS_W-1:0] y;
    // Outputs
    logic cap_start;
    logic frame_req;
    logic [roi_seq_pkg::EXP_W-1:0] exposure;
    logic [roi_seq_pkg::GAIN_W-1:0] gain;
    roi_seq_pkg::video_t vout;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;

  roi_seq_pkg::tbl_wr_t seq_wr;
  roi_seq_pkg::tbl_wr_t multi_wr;
  logic halve;
  roi_seq_pkg::entry_t seq_rd_a;
  roi_seq_pkg::entry_t seq_rd_b;
  roi_seq_pkg::entry_t multi_rd_a;
  roi_seq_pkg::entry_t multi_rd_b;

  roi_table_mem #(.DEPTH(roi_seq_pkg::SEQ_ENTRIES)) u_seq_tbl (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr(seq_wr),
    .i_halve(halve),
    .i_rd_a_idx(s_r.seq_sel),
    .o_rd_a(seq_rd_a),
    .i_rd_b_idx(s_r.cur),
    .o_rd_b(seq_rd_b)
  );

  roi_table_mem #(.DEPTH(roi_seq_pkg::MULTI_ENTRIES)) u_multi_tbl (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr(multi_wr),
    .i_halve(halve),
    .i_rd_a_idx(s_r.multi_sel),
    .o_rd_a(multi_rd_a),
    .i_rd_b_idx(s_r.cur),
    .o_rd_b(multi_rd_b)
  );

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic setup_ph;
  logic first_acc;
  logic acc_done;
  logic hit;
  logic is_seq_fld;
  logic is_multi_fld;
  logic [2:0] fld;
  logic [31:0] cur_val;
  logic [31:0] wval;
  logic trg_edge;
  logic xfr_edge;
  logic fv_fall;
  logic in_roi;
  logic seq_reset;
  logic chain_end;
  logic [roi_seq_pkg::IDX_W-1:0] next_idx;
  logic [roi_seq_pkg::CNT_W-1:0] fc_max;
  roi_seq_pkg::entry_t rd_b;
  logic [11:0] fld_ofs;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cap_start = 1'b0;
    s_nxt.frame_req = 1'b0;
    seq_wr = '0;
    multi_wr = '0;
    halve = 1'b0;
    seq_reset = 1'b0;

    // Two flops on each pin before any edge logic
    s_nxt.trg_s = {s_r.trg_s[0], i_trigger};
    s_nxt.trg_d = s_r.trg_s[1];
    s_nxt.xfr_s = {s_r.xfr_s[0], i_xfer_trigger};
    s_nxt.xfr_d = s_r.xfr_s[1];
    trg_edge = s_r.trg_s[1] & ~s_r.trg_d;
    xfr_edge = s_r.xfr_s[1] & ~s_r.xfr_d;
    s_nxt.fv_d = i_video.frame_valid;
    s_nxt.lv_d = i_video.line_valid;
    fv_fall = s_r.fv_d & ~i_video.frame_valid;

    // Register decode
    setup_ph = i_psel & ~i_penable;
    first_acc = i_psel & i_penable & ~s_r.apb_wait;
    acc_done = i_psel & i_penable & s_r.apb_wait;
    is_seq_fld = i_paddr >= roi_seq_pkg::OFS_SEQ_FLD && i_paddr < roi_seq_pkg::OFS_MULTI_FLD;
    is_multi_fld = i_paddr >= roi_seq_pkg::OFS_MULTI_FLD && i_paddr < roi_seq_pkg::OFS_STATUS;
    fld_ofs = i_paddr - (is_seq_fld ? roi_seq_pkg::OFS_SEQ_FLD : roi_seq_pkg::OFS_MULTI_FLD);
    fld = fld_ofs[4:2];
    hit = i_paddr[1:0] == 2'h0;
    cur_val = 32'h0;
    if (is_seq_fld) begin
      cur_val = roi_seq_pkg::get_field(seq_rd_a, fld);
    end else if (is_multi_fld) begin
      // Regions carry no exposure, gain or count
      if (fld == roi_seq_pkg::FLD_EXPOSURE || fld == roi_seq_pkg::FLD_GAIN ||
          fld == roi_seq_pkg::FLD_FCOUNT) begin
        cur_val = 32'h0;
      end else begin
        cur_val = roi_seq_pkg::get_field(multi_rd_a, fld);
      end
    end else begin
      unique case (i_paddr)
        roi_seq_pkg::OFS_CTRL: begin
          cur_val[roi_seq_pkg::CTRL_MODE_LSB +: 2] = s_r.mode;
          cur_val[roi_seq_pkg::CTRL_BIN] = s_r.binning;
          cur_val[roi_seq_pkg::CTRL_DELAY] = s_r.delay_en;
        end
        roi_seq_pkg::OFS_REPEAT: cur_val[roi_seq_pkg::CNT_W-1:0] = s_r.repeat_cnt;
        roi_seq_pkg::OFS_SEQ_SEL: cur_val[roi_seq_pkg::IDX_W-1:0] = s_r.seq_sel;
        roi_seq_pkg::OFS_MULTI_SEL: cur_val[roi_seq_pkg::IDX_W-1:0] = s_r.multi_sel;
        roi_seq_pkg::OFS_STATUS: begin
          cur_val = {9'h0, s_r.st, s_r.rep, s_r.fcnt, s_r.cur};
        end
        default: hit = 1'b0;
      endcase
    end
    wval = merge(cur_val, i_pwdata, i_pstrb);

    // One wait state: read data registered in the first access cycle
    if (first_acc) begin
      s_nxt.apb_wait = 1'b1;
      // Refused reads return zero, misaligned field reads included
      s_nxt.prdata = (i_pwrite || !hit) ? 32'h0 : cur_val;
      s_nxt.slverr = ~hit;
    end
    if (acc_done) begin
      s_nxt.apb_wait = 1'b0;
    end
    if (setup_ph) begin
      s_nxt.apb_wait = 1'b0;
    end

    if (acc_done && i_pwrite && hit) begin
      if (is_seq_fld) begin
        seq_wr = '{en: 1'b1, idx: s_r.seq_sel, field: fld, data: wval};
      end else if (is_multi_fld) begin
        multi_wr = '{en: 1'b1, idx: s_r.multi_sel, field: fld, data: wval};
      end else begin
        unique case (i_paddr)
          roi_seq_pkg::OFS_CTRL: begin
            s_nxt.mode = wval[roi_seq_pkg::CTRL_MODE_LSB +: 2];
            s_nxt.binning = wval[roi_seq_pkg::CTRL_BIN];
            s_nxt.delay_en = wval[roi_seq_pkg::CTRL_DELAY];
            // Only the off-to-on change shrinks the tables
            halve = wval[roi_seq_pkg::CTRL_BIN] & ~s_r.binning;
            seq_reset = wval[roi_seq_pkg::CTRL_SEQ_RST] & i_pstrb[0];
          end
          roi_seq_pkg::OFS_REPEAT: s_nxt.repeat_cnt = wval[roi_seq_pkg::CNT_W-1:0];
          roi_seq_pkg::OFS_SEQ_SEL: s_nxt.seq_sel = wval[roi_seq_pkg::IDX_W-1:0];
          roi_seq_pkg::OFS_MULTI_SEL: s_nxt.multi_sel = wval[roi_seq_pkg::IDX_W-1:0];
          default: s_nxt.slverr = s_r.slverr;
        endcase
      end
    end

    // Table feeding the engine follows the mode
    rd_b = (s_r.mode == roi_seq_pkg::MODE_MULTI) ? multi_rd_b : seq_rd_b;
    next_idx = s_r.ent.next;
    if (s_r.mode == roi_seq_pkg::MODE_MULTI) begin
      if (next_idx >= roi_seq_pkg::IDX_W'(roi_seq_pkg::MULTI_ENTRIES)) begin
        next_idx = '0;
      end
    end else if (next_idx >= roi_seq_pkg::IDX_W'(roi_seq_pkg::SEQ_ENTRIES)) begin
      next_idx = '0;
    end
    fc_max = (s_r.ent.fcount == '0) ? 8'h01 : s_r.ent.fcount;
    chain_end = 1'b0;

    // Region window on the replayed frame
    if (i_video.line_valid) begin
      s_nxt.x = s_r.x + 13'h1;
    end else begin
      s_nxt.x = '0;
    end
    if (s_r.lv_d && !i_video.line_valid) begin
      s_nxt.y = s_r.y + 13'h1;
    end
    if (!i_video.frame_valid) begin
      s_nxt.y = '0;
    end
    // Each region is judged alone, so overlaps come out whole
    in_roi = i_video.line_valid &&
      s_r.x >= {1'b0, s_r.ent.offx} && s_r.x < {1'b0, s_r.ent.offx} + {1'b0, s_r.ent.width} &&
      s_r.y >= {1'b0, s_r.ent.offy} &&
      s_r.y < {1'b0, s_r.ent.offy} + {1'b0, s_r.ent.height};

    s_nxt.vout = '0;
    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.mode == roi_seq_pkg::MODE_NORMAL) begin
          s_nxt.vout = i_video;
        end else if (s_r.mode != 2'h3) begin
          s_nxt.st = ST_LOAD;
        end
      end
      ST_LOAD: s_nxt.st = ST_LATCH;
      ST_LATCH: begin
        s_nxt.ent = rd_b;
        if (s_r.mode == roi_seq_pkg::MODE_MULTI && s_r.rcnt != 3'h0) begin
          s_nxt.st = ST_XFER_WAIT;
        end else begin
          s_nxt.st = ST_ARM;
        end
      end
      ST_ARM: begin
        if (s_r.mode == roi_seq_pkg::MODE_SEQ && trg_edge) begin
          // Exposure starts at the trigger, never on the line clock
          s_nxt.cap_start = 1'b1;
          s_nxt.exposure = s_r.ent.exposure;
          s_nxt.gain = s_r.ent.gain;
          s_nxt.st = ST_CAPTURE;
        end else if (s_r.mode == roi_seq_pkg::MODE_MULTI && i_frame_stored) begin
          s_nxt.st = ST_XFER_WAIT;
        end
      end
      ST_CAPTURE: begin
        if (i_frame_stored) begin
          s_nxt.st = ST_XFER_WAIT;
        end
      end
      ST_XFER_WAIT: begin
        // Later regions of one image reuse the same stored frame
        if (!s_r.delay_en || xfr_edge || s_r.rcnt != 3'h0) begin
          s_nxt.frame_req = 1'b1;
          s_nxt.st = ST_STREAM;
        end
      end
      ST_STREAM: begin
        s_nxt.vout.frame_valid = i_video.frame_valid;
        s_nxt.vout.line_valid = in_roi;
        s_nxt.vout.pix = in_roi ? i_video.pix : '0;
        if (fv_fall) begin
          if (s_r.mode == roi_seq_pkg::MODE_MULTI) begin
            chain_end = next_idx == '0 ||
              s_r.rcnt == 3'(roi_seq_pkg::MULTI_ENTRIES - 1);
            s_nxt.rcnt = chain_end ? 3'h0 : s_r.rcnt + 3'h1;
            s_nxt.cur = chain_end ? '0 : next_idx;
            s_nxt.st = ST_LOAD;
          end else if (s_r.fcnt + 8'h1 < fc_max) begin
            s_nxt.fcnt = s_r.fcnt + 8'h1;
            s_nxt.st = ST_ARM;
          end else begin
            s_nxt.fcnt = '0;
            s_nxt.cur = next_idx;
            s_nxt.st = ST_LOAD;
            if (next_idx == '0) begin
              s_nxt.rep = s_r.rep + 8'h1;
              if (s_r.repeat_cnt != '0 && s_r.rep + 8'h1 == s_r.repeat_cnt) begin
                s_nxt.st = ST_DONE;
              end
            end
          end
        end
      end
      ST_DONE: s_nxt.st = ST_DONE;
    endcase

    // A mode change or sequence reset restarts at the first entry
    if (seq_reset || (acc_done && i_pwrite && hit && i_paddr == roi_seq_pkg::OFS_CTRL &&
        wval[roi_seq_pkg::CTRL_MODE_LSB +: 2] != s_r.mode)) begin
      s_nxt.st = ST_IDLE;
      s_nxt.cur = '0;
      s_nxt.fcnt = '0;
      s_nxt.rep = '0;
      s_nxt.rcnt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.repeat_cnt <= roi_seq_pkg::RST_REPEAT;
      s_r.ent <= roi_seq_pkg::ENTRY_DEFAULT;
      s_r.exposure <= roi_seq_pkg::RST_EXPOSURE;
      s_r.gain <= roi_seq_pkg::RST_GAIN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata = s_r.prdata;
  assign o_pready = i_psel & i_penable & s_r.apb_wait;
  assign o_pslverr = o_pready & s_r.slverr;
  assign o_cap_start = s_r.cap_start;
  assign o_exposure = s_r.exposure;
  assign o_gain = s_r.gain;
  assign o_frame_req = s_r.frame_req;
  assign o_video = s_r.vout;
  assign o_active_index = s_r.cur;

endmodule

// ===== src/roi_table_mem.sv
// Purpose: Entry table with reset defaults, one write port and two read ports
// Assumes: Index beyond DEPTH reads the default entry and ignores writes
// Notes: Both read ports come out of registers, one cycle after the index
`timescale 1ns/1ns
module roi_table_mem #(
  parameter int DEPTH = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Write and bulk halve
  input wire roi_seq_pkg::tbl_wr_t i_wr,
  input wire logic i_halve,
  // Read ports
  input wire logic [roi_seq_pkg::IDX_W-1:0] i_rd_a_idx,
  output roi_seq_pkg::entry_t o_rd_a,
  input wire logic [roi_seq_pkg::IDX_W-1:0] i_rd_b_idx,
  output roi_seq_pkg::entry_t o_rd_b
);

  typedef struct packed {
    roi_seq_pkg::entry_t [DEPTH-1:0] mem;
    roi_seq_pkg::entry_t rd_a;
    roi_seq_pkg::entry_t rd_b;
  } mem_state_t;

  mem_state_t s_r;
  mem_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < DEPTH; i++) begin
      if (i_halve) begin
        s_nxt.mem[i].width = s_r.mem[i].width >> 1;
        s_nxt.mem[i].height = s_r.mem[i].height >> 1;
        s_nxt.mem[i].offx = s_r.mem[i].offx >> 1;
        s_nxt.mem[i].offy = s_r.mem[i].offy >> 1;
      end
      if (i_wr.en && i_wr.idx == roi_seq_pkg::IDX_W'(i)) begin
        s_nxt.mem[i] = roi_seq_pkg::set_field(s_nxt.mem[i], i_wr.field, i_wr.data);
      end
    end
    s_nxt.rd_a = roi_seq_pkg::ENTRY_DEFAULT;
    s_nxt.rd_b = roi_seq_pkg::ENTRY_DEFAULT;
    for (int i = 0; i < DEPTH; i++) begin
      if (i_rd_a_idx == roi_seq_pkg::IDX_W'(i)) begin
        s_nxt.rd_a = s_r.mem[i];
      end
      if (i_rd_b_idx == roi_seq_pkg::IDX_W'(i)) begin
        s_nxt.rd_b = s_r.mem[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r.mem <= {DEPTH{roi_seq_pkg::ENTRY_DEFAULT}};
      s_r.rd_a <= roi_seq_pkg::ENTRY_DEFAULT;
      s_r.rd_b <= roi_seq_pkg::ENTRY_DEFAULT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rd_a = s_r.rd_a;
  assign o_rd_b = s_r.rd_b;

endmodule
